/* hw/acr_pkg.sv */
package acr_pkg;
    ////////////////////////////////////////////////////////////////////////////////
    // coprocessor-15 register selectors
    localparam logic [2:0] OPC1_SEL      = 3'h0;   // first opcode
    localparam logic [3:0] CRN_SEL       = 4'h1;   // primary register c1
    localparam logic [3:0] CRM_SEL       = 4'h0;   // secondary register c0
    localparam logic [2:0] OPC2_AUX      = 3'h1;   // auxiliary control
    localparam logic [2:0] OPC2_CPAC     = 3'h2;   // coprocessor access control

    ////////////////////////////////////////////////////////////////////////////////
    // auxiliary control field positions
    localparam int AUX_COHERENCY_BIT     = 6;
    localparam int AUX_ZERO_LINE_BIT     = 3;
    localparam int AUX_PREFETCH_BIT      = 2;
    localparam int AUX_UNK_BIT           = 1;
    localparam int AUX_BROADCAST_BIT     = 0;
    localparam logic [31:0] AUX_RESET    = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // coprocessor access control field positions
    localparam int CPAC_SIMD_DIS_BIT     = 31;
    localparam int CPAC_UPPER_DIS_BIT    = 30;
    localparam int CPAC_COPROC_ELEVEN_PERMISSION_LSB         = 22;
    localparam int CPAC_COPROC_TEN_PERMISSION_LSB         = 20;
    localparam logic [1:0] PERM_RESET    = 2'h0;
    localparam logic [1:0] PERM_DENIED   = 2'h0;
    localparam logic [1:0] PERM_PRIV     = 2'h1;
    localparam logic [1:0] PERM_RSVD     = 2'h2;
    localparam logic [1:0] PERM_FULL     = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // processor mode field
    localparam logic [4:0] MODE_USER     = 5'h10;

    // a coprocessor-15 move request
    typedef struct packed {
        logic        valid;     // request strobe
        logic        write;     // 1 move to coprocessor, 0 move from
        logic [2:0]  opc1;      // first opcode
        logic [3:0]  crn;       // primary register
        logic [3:0]  crm;       // secondary register
        logic [2:0]  opc2;      // second opcode
        logic [31:0] wdata;     // write value
    } acr_req_t;

    // answer to a request
    typedef struct packed {
        logic        valid;     // answer strobe
        logic        undef;     // undefined instruction raised
        logic [31:0] rdata;     // read value
    } acr_rsp_t;
endpackage

/* hw/acr_regs.sv */
// Notes on behaviour
// RL1: bit 6 marks coherency participation, reset zero
// RL2: single core with bit 6: shared inner is cacheable
// RL3: bit 3 enables zero-line writes, reset zero
// RL4: software enables zero-line only if slaves support
// RL5: bit 2 enables data prefetch, reset disabled
// RL6: bit 0 enables maintenance broadcast, reset zero
// RL7: single core: broadcast bit reads zero, ignores writes
// RL8: software updates auxiliary control by read-modify-write
// RL9: auxiliary control at opcode 0, c1, c0, 1
// RL10: locked secure write raises undefined, no update
// RL11: access control sets coproc_eleven_permission/coproc_ten_permission rights, shows presence
// RL12: access control never gates coprocessors 14, 15
// RL13: privileged only, one copy for both states
// RL14: bit 31 disables non-float SIMD instructions
// RL15: SIMD-disable unknown without units, one float-only
// RL16: bit 30 disables upper double registers
// RL17: float-only: bit 30 reads one, ignores writes
// RL18: permission codes denied, privileged, reserved, full
// RL19: fields at 23:22, 21:20; rest read zero
// RL20: absent coprocessor field stays denied after writes
// RL21: aux bits 5:4 read zero; bit 1 ignored
// RL22: user mode access undefined, registers unchanged
module acr_regs
#(
    parameter bit MULTI_CORE   = 1'b1,  // more than one core in the cluster
    parameter bit HAS_FLOAT    = 1'b1,  // floating-point unit present
    parameter bit HAS_SIMD     = 1'b1   // SIMD unit present
)
(
    input  wire logic             sys_clk_in,              // core clock
    input  wire logic             resetn_in,               // core reset, active low
    input  wire acr_pkg::acr_req_t req_in,                 // coprocessor-15 move request
    input  wire logic [4:0]       mode_in,                 // current processor mode
    input  wire logic             secure_in,               // secure state
    input  wire logic             secure_register_lock_in, // secure register lock pin
    input  wire logic [3:0]       copro_num_in,            // coprocessor of an instruction
    input  wire logic             simd_op_in,              // instruction is non-float SIMD
    input  wire logic             upper_bank_op_in,        // instruction uses D16-D31
    output acr_pkg::acr_rsp_t     rsp_out,                 // answer to a request
    output logic                  copro_undef_out,         // coprocessor instruction refused
    output logic                  coherency_participation_out, // coherency participation
    output logic                  shared_as_cacheable_out, // inner shared treated cacheable
    output logic                  zero_line_enable_out,    // zero-line write mode
    output logic                  prefetch_enable_out,     // data-side prefetch
    output logic                  maintenance_broadcast_enable_out // broadcast enable
);
    ////////////////////////////////////////////////////////////////////////////////
    // build options
    localparam bit       FLOAT_ONLY = HAS_FLOAT && !HAS_SIMD; // float unit without SIMD

    ////////////////////////////////////////////////////////////////////////////////
    // state
    logic [6:0]          aux_reg;            // auxiliary control low bits
    logic [6:0]          aux_next;
    logic                simd_disable_reg;   // SIMD disable
    logic                simd_disable_next;
    logic                upper_bank_disable_reg; // upper bank disable
    logic                upper_bank_disable_next;
    logic [1:0]          coproc_eleven_permission_reg;
    logic [1:0]          coproc_eleven_permission_next;
    logic [1:0]          coproc_ten_permission_reg;
    logic [1:0]          coproc_ten_permission_next;
    acr_pkg::acr_rsp_t   rsp_reg;            // registered answer
    acr_pkg::acr_rsp_t   rsp_next;

    // decode helpers
    logic                hit_aux;            // request names auxiliary control
    logic                hit_cpac;           // request names access control
    logic                user_mode;          // unprivileged
    logic [31:0]         aux_view;           // readback of auxiliary control
    logic [31:0]         cpac_view;          // readback of access control
    logic                locked;             // secure state with the lock high
    logic                aux_write;          // accepted auxiliary write
    logic                cpac_write;         // accepted access control write
    logic                unit_off;           // instruction hits a disabled unit

    ////////////////////////////////////////////////////////////////////////////////
    // write filter for a permission field: absent units keep denied
    function automatic logic [1:0] perm_filter(input logic present, input logic [1:0] val);
        perm_filter = present ? val : acr_pkg::PERM_DENIED; // RL20
    endfunction

    // permission check for an instruction against a field
    function automatic logic perm_refuses(input logic [1:0] perm, input logic user);
        case (perm)
            acr_pkg::PERM_PRIV: perm_refuses = user;     // RL18
            acr_pkg::PERM_FULL: perm_refuses = 1'b0;     // RL18
            default:            perm_refuses = 1'b1;     // denied or reserved RL18
        endcase
    endfunction

    // match of a move request against one register selector
    function automatic logic selects(input acr_pkg::acr_req_t req, input logic [2:0] opc2);
        selects = req.opc1 == acr_pkg::OPC1_SEL
               && req.crn == acr_pkg::CRN_SEL
               && req.crm == acr_pkg::CRM_SEL
               && req.opc2 == opc2;                                    // RL9
    endfunction

    // refusal of a coprocessor 10 or 11 instruction
    function automatic logic insn_refuses(input logic [1:0] perm, input logic user,
                                          input logic off);
        insn_refuses = perm_refuses(perm, user) || off;                // RL18
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // request decode
    always_comb
    begin
        hit_aux    = req_in.valid && selects(req_in, acr_pkg::OPC2_AUX);    // RL9
        hit_cpac   = req_in.valid && selects(req_in, acr_pkg::OPC2_CPAC);   // RL9
        user_mode  = mode_in == acr_pkg::MODE_USER;                         // RL13
        locked     = secure_in && secure_register_lock_in;                  // RL10
        // a refused write leaves the register unchanged RL22
        aux_write  = hit_aux && req_in.write && !user_mode && !locked;      // RL10
        cpac_write = hit_cpac && req_in.write && !user_mode;                // RL13
        // SIMD or upper-bank op while that part is disabled
        unit_off   = (simd_op_in && simd_disable_reg)                       // RL14
                  || (upper_bank_op_in && upper_bank_disable_reg);          // RL16
    end


    ////////////////////////////////////////////////////////////////////////////////
    // readback views; unlisted bits read zero
    always_comb
    begin
        aux_view = 32'h0000_0000;                                          // RL21
        aux_view[acr_pkg::AUX_COHERENCY_BIT] = aux_reg[acr_pkg::AUX_COHERENCY_BIT];
        aux_view[acr_pkg::AUX_ZERO_LINE_BIT] = aux_reg[acr_pkg::AUX_ZERO_LINE_BIT];
        aux_view[acr_pkg::AUX_PREFETCH_BIT]  = aux_reg[acr_pkg::AUX_PREFETCH_BIT];
        aux_view[acr_pkg::AUX_BROADCAST_BIT] = MULTI_CORE
                                             & aux_reg[acr_pkg::AUX_BROADCAST_BIT]; // RL7
        cpac_view = 32'h0000_0000;                                         // RL19
        cpac_view[acr_pkg::CPAC_SIMD_DIS_BIT]  = simd_disable_reg;
        cpac_view[acr_pkg::CPAC_UPPER_DIS_BIT] = upper_bank_disable_reg;
        cpac_view[acr_pkg::CPAC_COPROC_ELEVEN_PERMISSION_LSB +: 2] = coproc_eleven_permission_reg; // RL11
        cpac_view[acr_pkg::CPAC_COPROC_TEN_PERMISSION_LSB +: 2] = coproc_ten_permission_reg;
    end


    ////////////////////////////////////////////////////////////////////////////////
    // auxiliary control: next value, writable bits only
    always_comb
    begin
        aux_next = aux_reg;                                        // hold by default
        if (aux_write)
        begin
            // bits 5:4 and 1 are not stored RL21
            aux_next[acr_pkg::AUX_COHERENCY_BIT] =
                req_in.wdata[acr_pkg::AUX_COHERENCY_BIT];          // RL1
            aux_next[acr_pkg::AUX_ZERO_LINE_BIT] =
                req_in.wdata[acr_pkg::AUX_ZERO_LINE_BIT];          // RL3
            aux_next[acr_pkg::AUX_PREFETCH_BIT]  =
                req_in.wdata[acr_pkg::AUX_PREFETCH_BIT];           // RL5
            // single core keeps the broadcast bit at zero
            aux_next[acr_pkg::AUX_BROADCAST_BIT] = MULTI_CORE
                & req_in.wdata[acr_pkg::AUX_BROADCAST_BIT];        // RL6 RL7
        end
    end

    // auxiliary control register, cleared by core reset
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            aux_reg <= acr_pkg::AUX_RESET[6:0];                    // RL1 RL3 RL5 RL6
        end
        else
        begin
            aux_reg <= aux_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // access control: next value, one copy for both states RL13
    always_comb
    begin
        simd_disable_next             = simd_disable_reg;          // hold by default
        upper_bank_disable_next       = upper_bank_disable_reg;
        coproc_eleven_permission_next = coproc_eleven_permission_reg;
        coproc_ten_permission_next    = coproc_ten_permission_reg;
        if (cpac_write)
        begin
            // float-only build keeps both disable bits at one
            simd_disable_next = FLOAT_ONLY ? 1'b1
                : req_in.wdata[acr_pkg::CPAC_SIMD_DIS_BIT];        // RL15
            upper_bank_disable_next = FLOAT_ONLY ? 1'b1
                : req_in.wdata[acr_pkg::CPAC_UPPER_DIS_BIT];       // RL17
            // absent float unit leaves both fields denied
            coproc_eleven_permission_next = perm_filter(HAS_FLOAT,
                req_in.wdata[acr_pkg::CPAC_COPROC_ELEVEN_PERMISSION_LSB +: 2]);        // RL19 RL20
            coproc_ten_permission_next = perm_filter(HAS_FLOAT,
                req_in.wdata[acr_pkg::CPAC_COPROC_TEN_PERMISSION_LSB +: 2]);        // RL19 RL20
        end
    end

    // access control register; float-only build resets the disable bits to one
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            simd_disable_reg             <= FLOAT_ONLY;            // RL15
            upper_bank_disable_reg       <= FLOAT_ONLY;            // RL17
            coproc_eleven_permission_reg <= acr_pkg::PERM_RESET;   // RL18
            coproc_ten_permission_reg    <= acr_pkg::PERM_RESET;
        end
        else
        begin
            simd_disable_reg             <= simd_disable_next;
            upper_bank_disable_reg       <= upper_bank_disable_next;
            coproc_eleven_permission_reg <= coproc_eleven_permission_next;
            coproc_ten_permission_reg    <= coproc_ten_permission_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // answer: next value, registered on the taking edge
    always_comb
    begin
        rsp_next = '0;                                             // no answer by default
        if (hit_aux || hit_cpac)
        begin
            rsp_next.valid = 1'b1;
            if (user_mode)
            begin
                // refused user access reads zero
                rsp_next.undef = 1'b1;                             // RL22 RL13
            end
            else if (req_in.write)
            begin
                // only the locked secure auxiliary write is refused
                rsp_next.undef = hit_aux && locked;                // RL10
            end
            else
            begin
                // privileged read returns the named view
                rsp_next.rdata = hit_aux ? aux_view : cpac_view;
            end
        end
    end

    // answer register, a one-cycle strobe
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rsp_reg <= '0;
        end
        else
        begin
            rsp_reg <= rsp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs to the core
    always_comb
    begin
        rsp_out                          = rsp_reg;
        coherency_participation_out      = aux_reg[acr_pkg::AUX_COHERENCY_BIT];  // RL1
        shared_as_cacheable_out          = !MULTI_CORE
                                         && aux_reg[acr_pkg::AUX_COHERENCY_BIT]; // RL2
        zero_line_enable_out             = aux_reg[acr_pkg::AUX_ZERO_LINE_BIT];  // RL3
        prefetch_enable_out              = aux_reg[acr_pkg::AUX_PREFETCH_BIT];   // RL5
        maintenance_broadcast_enable_out = aux_view[acr_pkg::AUX_BROADCAST_BIT]; // RL6
        // only coprocessors 10 and 11 are gated RL12
        case (copro_num_in)
            4'hA:    copro_undef_out = insn_refuses(coproc_ten_permission_reg,
                                                    user_mode, unit_off);     // RL11
            4'hB:    copro_undef_out = insn_refuses(coproc_eleven_permission_reg,
                                                    user_mode, unit_off);     // RL11
            default: copro_undef_out = 1'b0;                                   // RL12
        endcase
    end
endmodule

/* test/acr_regs_monitor.sv */
////////////////////////////////////////////////////////////////////////////////
// port checker for the system-control register pair
module acr_regs_monitor
(
    input wire logic              sys_clk_in,
    input wire logic              resetn_in,
    input wire acr_pkg::acr_req_t req_in,
    input wire logic [4:0]        mode_in,
    input wire logic              secure_in,
    input wire logic              secure_register_lock_in,
    input wire logic [3:0]        copro_num_in,
    input wire logic              simd_op_in,
    input wire logic              upper_bank_op_in,
    input wire acr_pkg::acr_rsp_t rsp_out,
    input wire logic              copro_undef_out,
    input wire logic              coherency_participation_out,
    input wire logic              shared_as_cacheable_out,
    input wire logic              zero_line_enable_out,
    input wire logic              prefetch_enable_out,
    input wire logic              maintenance_broadcast_enable_out
);
    logic sel_hit;   // request aimed at one of the two registers
    logic user_req;  // request made from user mode
    logic aux_wr;    // privileged auxiliary write
    logic locked;    // secure state with the lock pin high
    assign sel_hit = req_in.valid && req_in.opc1 == acr_pkg::OPC1_SEL
        && req_in.crn == acr_pkg::CRN_SEL && req_in.crm == acr_pkg::CRM_SEL
        && (req_in.opc2 == acr_pkg::OPC2_AUX || req_in.opc2 == acr_pkg::OPC2_CPAC);
    assign user_req = sel_hit && mode_in == acr_pkg::MODE_USER;
    assign aux_wr = sel_hit && req_in.write && req_in.opc2 == acr_pkg::OPC2_AUX && !user_req;
    assign locked = secure_in && secure_register_lock_in;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    ////////////////////////////////////////////////////////////////////////////////
    answer_timing_a: assert property (sel_hit |=> rsp_out.valid)
        else $error("no answer one cycle after a request");
    no_answer_a: assert property (req_in.valid && !sel_hit |=> !rsp_out.valid)
        else $error("answer to an unmatched selector");
    user_refuse_a: assert property (user_req |=> rsp_out.undef && rsp_out.rdata == 32'h0)
        else $error("user access not refused");
    user_hold_a: assert property (user_req |=> $stable({coherency_participation_out,
        zero_line_enable_out, prefetch_enable_out})) else $error("user access changed state");
    lock_refuse_a: assert property (aux_wr && locked |=> rsp_out.undef)
        else $error("locked secure write not refused");
    aux_update_a: assert property (aux_wr && !locked |=> prefetch_enable_out ==
        $past(req_in.wdata[2]) && zero_line_enable_out == $past(req_in.wdata[3])
        && coherency_participation_out == $past(req_in.wdata[6]))
        else $error("auxiliary outputs do not follow the write");
    cpac_zero_a: assert property (rsp_out.valid && $past(req_in.opc2) == acr_pkg::OPC2_CPAC
        |-> rsp_out.rdata[29:24] == 6'h00 && rsp_out.rdata[19:0] == 20'h00000)
        else $error("reserved access control bits not zero");
    aux_zero_a: assert property (rsp_out.valid && $past(req_in.opc2) == acr_pkg::OPC2_AUX
        |-> rsp_out.rdata[5:4] == 2'h0) else $error("auxiliary bits 5:4 not zero");
    cp_fourteen_a: assert property (copro_num_in inside {4'hE, 4'hF} |-> !copro_undef_out)
        else $error("coprocessor 14 or 15 refused");
    cover property (aux_wr && locked);
    cover property (user_req);
    cover property (aux_wr && !locked);
endmodule
bind acr_regs acr_regs_monitor u_mon (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .req_in(req_in), .mode_in(mode_in), .secure_in(secure_in),
    .secure_register_lock_in(secure_register_lock_in), .copro_num_in(copro_num_in),
    .simd_op_in(simd_op_in), .upper_bank_op_in(upper_bank_op_in), .rsp_out(rsp_out),
    .copro_undef_out(copro_undef_out), .coherency_participation_out(coherency_participation_out),
    .shared_as_cacheable_out(shared_as_cacheable_out), .zero_line_enable_out(zero_line_enable_out),
    .prefetch_enable_out(prefetch_enable_out),
    .maintenance_broadcast_enable_out(maintenance_broadcast_enable_out));

/* test/acr_regs_bench.sv */
module acr_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic              sys_clk_in = 1'b0;     // 125 MHz core clock
    logic              resetn_in = 1'b0;      // core reset, active low
    acr_pkg::acr_req_t req_in = '0;           // move request
    logic [4:0]        mode_in = 5'h13;       // privileged mode by default
    logic              secure_in = 1'b1;      // secure state
    logic              lock_in = 1'b0;        // secure register lock
    logic [3:0]        copro_num_in = 4'hA;   // coprocessor under check
    logic              simd_op_in = 1'b0;     // non-float SIMD op
    logic              upper_op_in = 1'b0;    // op touching upper bank
    acr_pkg::acr_rsp_t rsp_out;               // answer
    logic              undef_out, coh_out, sac_out, zl_out, pf_out, bc_out;
    int                error_cnt = 0;         // mismatches
    int                checked = 0;           // comparisons
    always #4 sys_clk_in = ~sys_clk_in;
    acr_regs dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .req_in(req_in),
        .mode_in(mode_in), .secure_in(secure_in), .secure_register_lock_in(lock_in),
        .copro_num_in(copro_num_in), .simd_op_in(simd_op_in), .upper_bank_op_in(upper_op_in),
        .rsp_out(rsp_out), .copro_undef_out(undef_out), .coherency_participation_out(coh_out),
        .shared_as_cacheable_out(sac_out), .zero_line_enable_out(zl_out),
        .prefetch_enable_out(pf_out), .maintenance_broadcast_enable_out(bc_out));
    acr_pkg::acr_rsp_t rsp_one_out, rsp_none_out; // answers of the reduced builds
    logic              sac_one_out, bc_one_out;   // single-core enables
    // single core, float unit only
    acr_regs #(.MULTI_CORE(1'b0), .HAS_FLOAT(1'b1), .HAS_SIMD(1'b0)) dut_one (
        .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .req_in(req_in), .mode_in(mode_in),
        .secure_in(secure_in), .secure_register_lock_in(lock_in), .copro_num_in(copro_num_in),
        .simd_op_in(simd_op_in), .upper_bank_op_in(upper_op_in), .rsp_out(rsp_one_out),
        .copro_undef_out(), .coherency_participation_out(),
        .shared_as_cacheable_out(sac_one_out), .zero_line_enable_out(),
        .prefetch_enable_out(), .maintenance_broadcast_enable_out(bc_one_out));
    // neither float nor SIMD unit
    acr_regs #(.MULTI_CORE(1'b1), .HAS_FLOAT(1'b0), .HAS_SIMD(1'b0)) dut_none (
        .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .req_in(req_in), .mode_in(mode_in),
        .secure_in(secure_in), .secure_register_lock_in(lock_in), .copro_num_in(copro_num_in),
        .simd_op_in(simd_op_in), .upper_bank_op_in(upper_op_in), .rsp_out(rsp_none_out),
        .copro_undef_out(), .coherency_participation_out(), .shared_as_cacheable_out(),
        .zero_line_enable_out(), .prefetch_enable_out(),
        .maintenance_broadcast_enable_out());
    ////////////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one move request, held for one taking edge, answer judged after it
    task automatic cop(input logic w, input logic [2:0] o2, input logic [31:0] wd,
        input logic exp_u, input logic [31:0] exp_rd);
        @(posedge sys_clk_in);
        #1;
        req_in = '{1'b1, w, acr_pkg::OPC1_SEL, acr_pkg::CRN_SEL, acr_pkg::CRM_SEL, o2, wd};
        @(posedge sys_clk_in);
        #1;
        req_in.valid = 1'b0;
        chk({31'h0, rsp_out.valid},
            {31'h0, o2 inside {acr_pkg::OPC2_AUX, acr_pkg::OPC2_CPAC}});
        chk({31'h0, rsp_out.undef}, {31'h0, exp_u});
        if (!w) chk(rsp_out.rdata, exp_rd);
    endtask
    // auxiliary enables packed as coherency, zero line, prefetch, broadcast;
    // the multi-core build never treats shared as cacheable
    task automatic outs(input logic [3:0] exp);
        chk({27'h0, sac_out, coh_out, zl_out, pf_out, bc_out}, {28'h0, exp});
    endtask
    // instruction check against the stored rights
    task automatic ichk(input logic [3:0] cp, input logic s, input logic u, input logic exp);
        @(posedge sys_clk_in);
        #1;
        copro_num_in = cp;
        simd_op_in = s;
        upper_op_in = u;
        #1;
        chk({31'h0, undef_out}, {31'h0, exp});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        cop(1'b0, acr_pkg::OPC2_AUX, 32'h0, 1'b0, acr_pkg::AUX_RESET);
        cop(1'b0, acr_pkg::OPC2_CPAC, 32'h0, 1'b0, 32'h0);
        cop(1'b1, 3'h3, 32'h7F, 1'b0, 32'h0);
        outs(4'h0);
        $display("test reset done");
    endtask
    task automatic t_aux();
        cop(1'b1, acr_pkg::OPC2_AUX, 32'h7F, 1'b0, 32'h0);
        outs(4'hF);
        cop(1'b0, acr_pkg::OPC2_AUX, 32'h0, 1'b0, 32'h4D);
        lock_in = 1'b1;
        cop(1'b1, acr_pkg::OPC2_AUX, 32'h0, 1'b1, 32'h0);
        cop(1'b0, acr_pkg::OPC2_AUX, 32'h0, 1'b0, 32'h4D);
        secure_in = 1'b0;
        cop(1'b1, acr_pkg::OPC2_AUX, 32'h4, 1'b0, 32'h0);
        outs(4'h2);
        lock_in = 1'b0;
        secure_in = 1'b1;
        mode_in = acr_pkg::MODE_USER;
        cop(1'b1, acr_pkg::OPC2_AUX, 32'h7F, 1'b1, 32'h0);
        cop(1'b0, acr_pkg::OPC2_CPAC, 32'h0, 1'b1, 32'h0);
        mode_in = 5'h13;
        outs(4'h2);
        $display("test auxiliary done");
    endtask
    task automatic t_cpac();
        cop(1'b1, acr_pkg::OPC2_CPAC, 32'hFFFF_FFFF, 1'b0, 32'h0);
        cop(1'b0, acr_pkg::OPC2_CPAC, 32'h0, 1'b0, 32'hC0F0_0000);
        secure_in = 1'b0;
        cop(1'b0, acr_pkg::OPC2_CPAC, 32'h0, 1'b0, 32'hC0F0_0000);
        secure_in = 1'b1;
        $display("test access control done");
    endtask
    task automatic t_perm();
        logic [1:0] p;
        for (int i = 0; i < 4; i++)
        begin
            p = i[1:0];
            mode_in = 5'h13;
            cop(1'b1, acr_pkg::OPC2_CPAC, {8'h00, p, p, 20'h0}, 1'b0, 32'h0);
            for (int u = 0; u < 2; u++)
            begin
                mode_in = (u == 1) ? acr_pkg::MODE_USER : 5'h13;
                ichk(4'hA, 1'b0, 1'b0, p == 2'h0 || p == 2'h2 || (p == 2'h1 && u == 1));
                ichk(4'hB, 1'b0, 1'b0, p == 2'h0 || p == 2'h2 || (p == 2'h1 && u == 1));
                ichk(4'hE, 1'b0, 1'b0, 1'b0);
            end
        end
        mode_in = 5'h13;
        $display("test permissions done");
    endtask
    task automatic t_simd();
        cop(1'b1, acr_pkg::OPC2_CPAC, 32'h80F0_0000, 1'b0, 32'h0);
        ichk(4'hA, 1'b1, 1'b0, 1'b1);
        ichk(4'hA, 1'b0, 1'b1, 1'b0);
        cop(1'b1, acr_pkg::OPC2_CPAC, 32'h40F0_0000, 1'b0, 32'h0);
        ichk(4'hB, 1'b0, 1'b1, 1'b1);
        ichk(4'hB, 1'b1, 1'b0, 1'b0);
        $display("test disables done");
    endtask
    // reduced builds: single core float only, and no units at all
    task automatic t_single();
        cop(1'b0, acr_pkg::OPC2_AUX, 32'h0, 1'b0, 32'h4);
        cop(1'b1, acr_pkg::OPC2_AUX, 32'h4D, 1'b0, 32'h0);
        chk({30'h0, sac_one_out, bc_one_out}, 32'h2);
        cop(1'b0, acr_pkg::OPC2_AUX, 32'h0, 1'b0, 32'h4D);
        chk(rsp_one_out.rdata, 32'h4C);
        cop(1'b1, acr_pkg::OPC2_CPAC, 32'h00F0_0000, 1'b0, 32'h0);
        cop(1'b0, acr_pkg::OPC2_CPAC, 32'h0, 1'b0, 32'h00F0_0000);
        chk(rsp_one_out.rdata, 32'hC0F0_0000);
        chk(rsp_none_out.rdata, 32'h0000_0000);
        $display("test reduced builds done");
    endtask
    task automatic results();
        $display("counts: %0d checked, %0d mismatches", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge sys_clk_in);
        #1;
        resetn_in = 1'b1;
        t_reset();
        t_aux();
        t_cpac();
        t_perm();
        t_simd();
        t_single();
        results();
    end
    // watchdog well beyond the roughly 80 cycles the tests need
    initial
    begin
        #20000;
        error_cnt++;
        results();
    end
endmodule
